/* core/level_sync.sv */
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes the inputs are quasi-static pins from outside the clock domain.
module level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // First stage only feeds the second stage
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // level_sync

/* core/shared_image_packer.sv */
// Packs analog results, input states and configuration flags into the
// 64-bit shared image that other network stations read.
// Assumes conversion results and the renew strobe come from sys_clk logic;
// switches and general inputs are pins and are synchronised here.
//
// Notes on behaviour
// - Channel 0 result sits in image bits 11..0.
// - General inputs 0..3 sit in image bits 12..15.
// - Channel 1 result sits in image bits 27..16.
// - Bit 28 is one when bipolar coding switch is on.
// - Bit 29 shows peak-cut, function-setting word bit 1.
// - Bit 30 is one when inversion is disabled (switch on).
// - Bit 31 shows trigger source, function-setting word bit 0.
// - Bit 44 is always zero.
// - Bits 46 and 47 mirror the two sampling-method switches.
// - Method code 00 cyclic, 01 single, 10 period, 11 moving average.
// - Channel 3 result sits in image bits 59..48.
// - Sequence number in bits 63..60 advances on every analog renewal.
// - Sequence counts from 1 up to F, then wraps to 1, never 0.
// - Sequence reads 0 after reset; reader treats analog values invalid then.
// - Bipolar coding maps mid-scale to 000, full 7FF, zero 800.
// - Inputs pass unchanged with inversion switch on, inverted with it off.
//
// Implementation choices: the address map and the address-and-strobe port.
module shared_image_packer
    import image_pack_pkg::*;
(
    input  wire logic                               sys_clk,
    input  wire logic                               rst,
    input  wire logic [image_pack_pkg::ADC_WIDTH-1:0] channel_zero_raw,
    input  wire logic [image_pack_pkg::ADC_WIDTH-1:0] channel_one_raw,
    input  wire logic [image_pack_pkg::ADC_WIDTH-1:0] channel_three_raw,
    input  wire logic                               renew_strobe,
    input  wire logic [3:0]                         general_input_bits,
    input  wire logic                               bipolar_coding_flag,
    input  wire logic                               input_logic_flip_flag,
    input  wire logic                               sampling_method_low,
    input  wire logic                               sampling_method_high,
    input  wire logic [image_pack_pkg::ADDR_WIDTH-1:0] reg_addr,
    input  wire logic [image_pack_pkg::DATA_WIDTH-1:0] reg_wdata,
    input  wire logic                               reg_write,
    input  wire logic                               reg_read,
    output logic      [image_pack_pkg::DATA_WIDTH-1:0] reg_rdata,
    output logic      [63:0]                        shared_image,
    output logic                                    analog_valid
);
    import image_pack_pkg::*;

    // Pins synchronised before any logic looks at them
    logic [7:0] pins_async;
    logic [7:0] pins_sync;
    assign pins_async = {sampling_method_high, sampling_method_low, input_logic_flip_flag,
                         bipolar_coding_flag, general_input_bits};

    level_sync #(.WIDTH(8)) i_level_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    // Named views of the synchronised pins
    wire logic [3:0] din_s      = pins_sync[3:0];
    wire logic       bipolar_s  = pins_sync[4];
    wire logic       inv_off_s  = pins_sync[5];
    wire logic       smode_lo_s = pins_sync[6];
    wire logic       smode_hi_s = pins_sync[7];

    // Inputs are inverted unless the switch selects positive logic
    wire logic [3:0] din_logic = inv_off_s ? din_s : ~din_s;

    // Bipolar coding re-centres the unipolar code by flipping the top bit
    wire logic [11:0] ch0_coded = bipolar_s ? (channel_zero_raw ^ BIPOLAR_FLIP) : channel_zero_raw;
    wire logic [11:0] ch1_coded = bipolar_s ? (channel_one_raw ^ BIPOLAR_FLIP) : channel_one_raw;
    wire logic [11:0] ch3_coded = bipolar_s ? (channel_three_raw ^ BIPOLAR_FLIP) : channel_three_raw;

    // Register decode
    logic [31:0] function_setting_word_q;
    logic [31:0] reg_rdata_d;
    logic [63:0] shared_image_d;
    logic [3:0]  renewal_counter_q;
    logic [3:0]  renewal_counter_d;
    logic [11:0] ch0_q;
    logic [11:0] ch1_q;
    logic [11:0] ch3_q;
    wire logic   wr_func  = reg_write && (reg_addr == REG_FUNC_SET);
    wire logic   rd_lo    = reg_addr == REG_IMAGE_LO;
    wire logic   rd_hi    = reg_addr == REG_IMAGE_HI;
    wire logic   rd_func  = reg_addr == REG_FUNC_SET;
    wire logic   rd_stat  = reg_addr == REG_STATUS;
    wire logic   peak_cut = function_setting_word_q[FUNC_PEAK_BIT];
    wire logic   sw_trig  = function_setting_word_q[FUNC_TRIG_BIT];
    wire smode_type smode = smode_type'({smode_hi_s, smode_lo_s});

    // Function-setting word, written by software only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            function_setting_word_q <= FUNC_SET_RESET;
        end else if (wr_func) begin
            function_setting_word_q <= reg_wdata;
        end
    end

    // Sequence wraps F to 1 so zero only ever means "nothing yet"
    assign renewal_counter_d = (renewal_counter_q == SEQ_LAST || renewal_counter_q == SEQ_RESET)
                               ? SEQ_FIRST : renewal_counter_q + 4'h1;

    // Analog snapshots and sequence advance together on each renewal
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            renewal_counter_q <= SEQ_RESET;
            ch0_q             <= ADC_ZERO;
            ch1_q             <= ADC_ZERO;
            ch3_q             <= ADC_ZERO;
        end else if (renew_strobe) begin
            renewal_counter_q <= renewal_counter_d;
            ch0_q             <= ch0_coded;
            ch1_q             <= ch1_coded;
            ch3_q             <= ch3_coded;
        end
    end

    // Image assembly; flags follow switches and the function word live, analog fields follow renewals
    always_comb begin
        shared_image_d                            = '0;
        shared_image_d[POS_CH0 +: 12]             = ch0_q;
        shared_image_d[POS_DIN +: 4]              = din_logic;
        shared_image_d[POS_CH1 +: 12]             = ch1_q;
        shared_image_d[POS_BIPOLAR]               = bipolar_s;
        shared_image_d[POS_PEAKCUT]               = peak_cut;
        shared_image_d[POS_INVOFF]                = inv_off_s;
        shared_image_d[POS_SWTRIG]                = sw_trig;
        shared_image_d[POS_CH2 +: 12]             = 12'h000;
        shared_image_d[POS_UNUSED44]              = 1'b0;
        shared_image_d[POS_RSVD45]                = 1'b0;
        shared_image_d[POS_SMODE +: 2]            = smode;
        shared_image_d[POS_CH3 +: 12]             = ch3_q;
        shared_image_d[POS_SEQ +: 4]              = renewal_counter_q;
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        reg_rdata_d = READ_ZERO;
        if (reg_read) begin
            if (rd_lo) begin
                reg_rdata_d = shared_image_d[31:0];
            end else if (rd_hi) begin
                reg_rdata_d = shared_image_d[63:32];
            end else if (rd_func) begin
                reg_rdata_d = function_setting_word_q;
            end else if (rd_stat) begin
                reg_rdata_d = {31'h0000_0000, renewal_counter_q != SEQ_RESET};
            end
        end
    end

    // Outputs come straight from flops so readers see one consistent image
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata    <= READ_ZERO;
            shared_image <= '0;
            analog_valid <= 1'b0;
        end else begin
            reg_rdata    <= reg_rdata_d;
            shared_image <= shared_image_d;
            analog_valid <= renewal_counter_q != SEQ_RESET;
        end
    end

    // Checks
    property p_seq_advance;
        @(posedge sys_clk) disable iff (rst)
        renew_strobe |=> renewal_counter_q == $past(renewal_counter_d);
    endproperty
    a_seq_advance: assert property (p_seq_advance) else $error("sequence did not advance");

    property p_seq_nonzero;
        @(posedge sys_clk) disable iff (rst)
        renewal_counter_q != SEQ_RESET |=> renewal_counter_q != SEQ_RESET;
    endproperty
    a_seq_nonzero: assert property (p_seq_nonzero) else $error("sequence returned to zero");

    property p_seq_wrap;
        @(posedge sys_clk) disable iff (rst)
        (renewal_counter_q == 4'hF && renew_strobe) |=> renewal_counter_q == 4'h1;
    endproperty
    a_seq_wrap: assert property (p_seq_wrap) else $error("sequence wrap wrong");

    property p_seq_hold;
        @(posedge sys_clk) disable iff (rst)
        !renew_strobe |=> $stable(renewal_counter_q);
    endproperty
    a_seq_hold: assert property (p_seq_hold) else $error("sequence moved without renewal");

    property p_unused_zero;
        @(posedge sys_clk) disable iff (rst)
        ##1 (shared_image[44] == 1'b0 && shared_image[45] == 1'b0 && shared_image[43:32] == 12'h000);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("reserved image bits not zero");

    property p_ch0_place;
        @(posedge sys_clk) disable iff (rst)
        renew_strobe |=> ##1 shared_image[11:0] == ($past(ch0_coded, 2));
    endproperty
    a_ch0_place: assert property (p_ch0_place) else $error("channel 0 misplaced");

    property p_ch3_place;
        @(posedge sys_clk) disable iff (rst)
        renew_strobe |=> ##1 shared_image[59:48] == ($past(ch3_coded, 2));
    endproperty
    a_ch3_place: assert property (p_ch3_place) else $error("channel 3 misplaced");

    // Image flop holds zero through reset, so attempts start only once reset is gone
    property p_din_inv;
        @(posedge sys_clk) disable iff (rst)
        !rst |=> shared_image[15:12] == ($past(inv_off_s) ? $past(din_s) : ~$past(din_s));
    endproperty
    a_din_inv: assert property (p_din_inv) else $error("general inputs wrong polarity");

    property p_flags;
        @(posedge sys_clk) disable iff (rst)
        !rst |=> shared_image[31:28] == {$past(sw_trig), $past(inv_off_s), $past(peak_cut), $past(bipolar_s)};
    endproperty
    a_flags: assert property (p_flags) else $error("indicator bits wrong");

    property p_smode;
        @(posedge sys_clk) disable iff (rst)
        !rst |=> shared_image[47:46] == {$past(smode_hi_s), $past(smode_lo_s)};
    endproperty
    a_smode: assert property (p_smode) else $error("sampling method bits wrong");

    // Sequence and validity checks
    property p_seq_image;
        @(posedge sys_clk) disable iff (rst)
        !rst |=> shared_image[63:60] == $past(renewal_counter_q);
    endproperty
    a_seq_image: assert property (p_seq_image) else $error("sequence field lags counter");

    property p_first_renew;
        @(posedge sys_clk) disable iff (rst)
        (renew_strobe && renewal_counter_q == SEQ_RESET) |=> renewal_counter_q == SEQ_FIRST;
    endproperty
    a_first_renew: assert property (p_first_renew) else $error("first renewal not one");

    property p_seq_step;
        @(posedge sys_clk) disable iff (rst)
        (renew_strobe && renewal_counter_q != SEQ_LAST && renewal_counter_q != SEQ_RESET)
            |=> renewal_counter_q == $past(renewal_counter_q) + 4'h1;
    endproperty
    a_seq_step: assert property (p_seq_step) else $error("sequence step wrong");

    property p_valid_tracks;
        @(posedge sys_clk) disable iff (rst)
        analog_valid == (shared_image[63:60] != SEQ_RESET);
    endproperty
    a_valid_tracks: assert property (p_valid_tracks) else $error("valid flag disagrees with sequence");

    // Coding checks on the captured snapshots
    property p_bip_mid;
        @(posedge sys_clk) disable iff (rst)
        (renew_strobe && bipolar_s && channel_zero_raw == 12'h800) |=> ch0_q == 12'h000;
    endproperty
    a_bip_mid: assert property (p_bip_mid) else $error("bipolar mid-scale code wrong");

    property p_bip_full;
        @(posedge sys_clk) disable iff (rst)
        (renew_strobe && bipolar_s && channel_one_raw == 12'hFFF) |=> ch1_q == 12'h7FF;
    endproperty
    a_bip_full: assert property (p_bip_full) else $error("bipolar full-scale code wrong");

    property p_bip_zero;
        @(posedge sys_clk) disable iff (rst)
        (renew_strobe && bipolar_s && channel_one_raw == 12'h000) |=> ch1_q == 12'h800;
    endproperty
    a_bip_zero: assert property (p_bip_zero) else $error("bipolar zero code wrong");

    property p_uni_pass;
        @(posedge sys_clk) disable iff (rst)
        (renew_strobe && !bipolar_s) |=> (ch0_q == $past(channel_zero_raw)
            && ch1_q == $past(channel_one_raw)
            && ch3_q == $past(channel_three_raw));
    endproperty
    a_uni_pass: assert property (p_uni_pass) else $error("unipolar code altered");

    // Snapshots move only on a renewal, so both image halves stay coherent between them
    property p_snap_hold;
        @(posedge sys_clk) disable iff (rst)
        !renew_strobe |=> ($stable(ch0_q) && $stable(ch1_q)
            && $stable(ch3_q));
    endproperty
    a_snap_hold: assert property (p_snap_hold) else $error("snapshot moved without renewal");

    property p_ch1_place;
        @(posedge sys_clk) disable iff (rst)
        renew_strobe |=> ##1 shared_image[27:16] == ($past(ch1_coded, 2));
    endproperty
    a_ch1_place: assert property (p_ch1_place) else $error("channel 1 misplaced");

    // Input polarity and method code checks
    property p_din_pass;
        @(posedge sys_clk) disable iff (rst)
        (!rst && inv_off_s) |=> shared_image[15:12] == $past(din_s);
    endproperty
    a_din_pass: assert property (p_din_pass) else $error("inputs inverted while switch on");

    property p_din_flip;
        @(posedge sys_clk) disable iff (rst)
        (!rst && !inv_off_s) |=> shared_image[15:12] == ~$past(din_s);
    endproperty
    a_din_flip: assert property (p_din_flip) else $error("inputs not inverted while switch off");

    property p_smode_single;
        @(posedge sys_clk) disable iff (rst)
        (!smode_hi_s && smode_lo_s) |=> shared_image[47:46] == SMODE_SINGLE;
    endproperty
    a_smode_single: assert property (p_smode_single) else $error("single trigger code wrong");

    property p_smode_period;
        @(posedge sys_clk) disable iff (rst)
        (smode_hi_s && !smode_lo_s) |=> shared_image[47:46] == SMODE_PERIOD;
    endproperty
    a_smode_period: assert property (p_smode_period) else $error("period average code wrong");

    // Function word and register read checks
    property p_func_write;
        @(posedge sys_clk) disable iff (rst)
        wr_func |=> function_setting_word_q == $past(reg_wdata);
    endproperty
    a_func_write: assert property (p_func_write) else $error("function word write lost");

    property p_func_hold;
        @(posedge sys_clk) disable iff (rst)
        !wr_func |=> $stable(function_setting_word_q);
    endproperty
    a_func_hold: assert property (p_func_hold) else $error("function word changed unwritten");

    property p_rd_lo;
        @(posedge sys_clk) disable iff (rst)
        (reg_read && rd_lo) |=> reg_rdata == shared_image[31:0];
    endproperty
    a_rd_lo: assert property (p_rd_lo) else $error("low image read differs");

    property p_rd_hi;
        @(posedge sys_clk) disable iff (rst)
        (reg_read && rd_hi) |=> reg_rdata == shared_image[63:32];
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("high image read differs");

    property p_rd_func;
        @(posedge sys_clk) disable iff (rst)
        (reg_read && rd_func) |=> reg_rdata == $past(function_setting_word_q);
    endproperty
    a_rd_func: assert property (p_rd_func) else $error("function word read differs");

    property p_rd_stat;
        @(posedge sys_clk) disable iff (rst)
        (reg_read && rd_stat) |=> reg_rdata == {31'h0000_0000, analog_valid};
    endproperty
    a_rd_stat: assert property (p_rd_stat) else $error("status read differs");
endmodule // shared_image_packer

/* pkg/image_pack_pkg.sv */
// Constants for the 64-bit shared image packer: field positions, resets, codes.
// Assumes a single 100 MHz clock domain and plain-port register access.
package image_pack_pkg;
    localparam int ADC_WIDTH       = 12;
    localparam int ADDR_WIDTH      = 4;
    localparam int DATA_WIDTH      = 32;
    // Field positions in the shared image
    localparam int POS_CH0         = 0;
    localparam int POS_DIN         = 12;
    localparam int POS_CH1         = 16;
    localparam int POS_BIPOLAR     = 28;
    localparam int POS_PEAKCUT     = 29;
    localparam int POS_INVOFF      = 30;
    localparam int POS_SWTRIG      = 31;
    localparam int POS_CH2         = 32;
    localparam int POS_UNUSED44    = 44;
    localparam int POS_RSVD45      = 45;
    localparam int POS_SMODE       = 46;
    localparam int POS_CH3         = 48;
    localparam int POS_SEQ         = 60;
    // Function-setting word bit positions
    localparam int FUNC_TRIG_BIT   = 0;
    localparam int FUNC_PEAK_BIT   = 1;
    // Sequence number values
    localparam logic [3:0] SEQ_RESET = 4'h0;
    localparam logic [3:0] SEQ_FIRST = 4'h1;
    localparam logic [3:0] SEQ_LAST  = 4'hF;
    // Conversion coding
    localparam logic [11:0] BIPOLAR_FLIP = 12'h800;
    localparam logic [11:0] ADC_ZERO     = 12'h000;
    // Register offsets (word index)
    localparam logic [3:0] REG_IMAGE_LO  = 4'h0;
    localparam logic [3:0] REG_IMAGE_HI  = 4'h1;
    localparam logic [3:0] REG_FUNC_SET  = 4'h2;
    localparam logic [3:0] REG_STATUS    = 4'h3;
    localparam logic [31:0] FUNC_SET_RESET = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO      = 32'h0000_0000;
    // Sampling method codes, bit 47 high and bit 46 low
    typedef enum logic [1:0] {
        SMODE_CYCLIC  = 2'b00,
        SMODE_SINGLE  = 2'b01,
        SMODE_PERIOD  = 2'b10,
        SMODE_MOVING  = 2'b11
    } smode_type;
endpackage

/* testbench/image_reader_model.sv */
// Far-side station model: watches the shared image and counts fresh analog data.
// Assumes the image is sampled on the clock that produces it.
module image_reader_model (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [63:0] shared_image,
    output int               fresh_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] seen_q;
    // A changed sequence number marks fresh data; zero means not yet valid
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            seen_q      <= 4'h0;
            fresh_count <= 0;
        end else if (shared_image[63:60] != seen_q) begin
            seen_q <= shared_image[63:60];
            if (shared_image[63:60] != 4'h0) begin
                fresh_count <= fresh_count + 1;
            end
        end
    end
endmodule // image_reader_model

/* testbench/tb_top.sv */
// Self-checking bench for the shared image packer: image compares and register reads.
// Assumes one 100 MHz clock and the reader model beside the design.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import image_pack_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] ch0 = 12'h000, ch1 = 12'h000, ch3 = 12'h000;
    logic [3:0]  gin = 4'h0, addr = 4'h0, seq = 4'h0;
    logic        renew = 1'b0, bip = 1'b0, flip = 1'b1, sm_lo = 1'b0, sm_hi = 1'b0;
    logic        wr_s = 1'b0, rd_s = 1'b0, valid;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [63:0] image;
    logic [1:0]  func_bits = 2'b00;
    logic [35:0] snap = 36'h0_0000_0000;
    logic [11:0] tab [4] = '{12'h000, 12'h800, 12'hFFF, 12'h7FF};
    int          n_fail = 0, checks = 0, fresh, cycles = 0, renews = 0;

    shared_image_packer i_shared_image_packer (.sys_clk(sys_clk), .rst(rst), .channel_zero_raw(ch0),
        .channel_one_raw(ch1), .channel_three_raw(ch3), .renew_strobe(renew), .general_input_bits(gin),
        .bipolar_coding_flag(bip), .input_logic_flip_flag(flip), .sampling_method_low(sm_lo),
        .sampling_method_high(sm_hi), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_s),
        .reg_read(rd_s), .reg_rdata(rdata), .shared_image(image), .analog_valid(valid));
    image_reader_model i_image_reader_model (.sys_clk(sys_clk), .rst(rst), .shared_image(image),
        .fresh_count(fresh));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic end_of_test();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        addr <= a; wdata <= v; wr_s <= 1'b1;
        @(posedge sys_clk);
        wr_s <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe was taken
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        addr <= a; rd_s <= 1'b1;
        @(posedge sys_clk);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic renew_once();
        @(posedge sys_clk);
        renew <= 1'b1;
        @(posedge sys_clk);
        renew <= 1'b0;
        seq = (seq == SEQ_LAST) ? SEQ_FIRST : seq + 4'h1;
        snap = {cod(ch3), cod(ch1), cod(ch0)};
        renews++;
    endtask

    function automatic logic [11:0] cod(input logic [11:0] r);
        return bip ? r ^ BIPOLAR_FLIP : r;
    endfunction

    // Image expected from the pins, the function word and the sequence model
    function automatic logic [63:0] exp_img();
        logic [63:0] e;
        e = 64'h0;
        e[11:0] = snap[11:0];
        e[15:12] = flip ? gin : ~gin;
        e[27:16] = snap[23:12];
        e[31:28] = {func_bits[0], flip, func_bits[1], bip};
        e[47:46] = {sm_hi, sm_lo};
        e[59:48] = snap[35:24];
        e[63:60] = seq;
        return e;
    endfunction

    // Pins need three edges to reach the image, a renewal two
    task automatic check_all();
        logic [63:0] e;
        repeat (4) @(posedge sys_clk);
        #1 e = exp_img();
        cmp(image, e);
        cmp({63'h0, valid}, {63'h0, seq != 4'h0});
        rd(REG_IMAGE_LO, d);
        cmp({32'h0, d}, {32'h0, e[31:0]});
        rd(REG_IMAGE_HI, d);
        cmp({32'h0, d}, {32'h0, e[63:32]});
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        check_all();
        rd(REG_STATUS, d);
        cmp({32'h0, d}, 64'h0);
        // Every sampling code, both codings, both inversion settings, scale end points
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            bip <= i[0]; flip <= i[1]; sm_lo <= i[0]; sm_hi <= i[1];
            gin <= 4'h3 << i;
            ch0 <= tab[i]; ch1 <= tab[3 - i]; ch3 <= tab[(i + 1) % 4];
            func_bits = i[1:0];
            wr(REG_FUNC_SET, {30'h0, func_bits});
            wr(REG_IMAGE_LO, 32'hFFFF_FFFF);
            renew_once();
            check_all();
        end
        rd(REG_FUNC_SET, d);
        cmp({32'h0, d}, {62'h0, func_bits});
        rd(4'h7, d);
        cmp({32'h0, d}, 64'h0);
        rd(REG_STATUS, d);
        cmp({32'h0, d}, 64'h1);
        // Run the sequence through F and back round to 1
        repeat (13) begin
            renew_once();
            check_all();
        end
        cmp(fresh, renews);
        // Second reset in mid-run clears sequence, snapshots and function word
        @(posedge sys_clk);
        rst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        seq = SEQ_RESET;
        func_bits = 2'b00;
        snap = 36'h0_0000_0000;
        check_all();
        end_of_test();
    end
endmodule // tb_top
